// [logic/ptr_core.sv]
// pressure threshold, reference, rate and output register logic
`timescale 1ns/10ps
`default_nettype none

module ptr_core
	import ptr_pkg::*;
#(
	parameter logic [7:0] ID_CODE = 8'h5a, // arbitrary value
	parameter int unsigned PERIOD_1_CYC = CLK_HZ / RATE_1_HZ,
	parameter int unsigned PERIOD_10_CYC = CLK_HZ / RATE_10_HZ,
	parameter int unsigned PERIOD_25_CYC = CLK_HZ / RATE_25_HZ,
	parameter int unsigned PERIOD_50_CYC = CLK_HZ / RATE_50_HZ,
	parameter int unsigned PERIOD_75_CYC = CLK_HZ / RATE_75_HZ
) (
	input wire logic sys_clk_i,
	input wire logic rst_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [6:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic sample_valid_i,
	input wire logic [23:0] sample_press_i,
	output logic [7:0] reg_rdata_o,
	output logic acquire_o,
	output logic wire_three_o,
	output logic press_high_o,
	output logic press_low_o
);
	logic [7:0] int_cfg_reg;
	logic [15:0] thr_reg;
	logic [7:0] ctrl1_reg;
	logic [7:0] ctrl2_reg;
	logic [23:0] ref_reg;
	logic [15:0] ofs_reg;
	logic az_act_reg;
	logic hold_act_reg;
	logic [2:0] src_reg;
	logic avail_reg;
	logic frozen_reg;
	logic [23:0] out_reg;
	logic [23:0] filt_reg;
	logic busy_reg;
	logic [31:0] cnt_reg;
	logic [2:0] rate;
	logic wr_cfg, wr_c1, wr_c2, rd_src, rd_top, take, tick, os_start, filt_on;
	logic signed [23:0] filt_step, meas, ref_use, out_val, comp;
	logic signed [25:0] comp_w, thr_w;
	logic hit_high, hit_low;

	function automatic int unsigned period_of(input logic [2:0] code);
		unique case (code)
			RATE_1: period_of = PERIOD_1_CYC;
			RATE_10: period_of = PERIOD_10_CYC;
			RATE_25: period_of = PERIOD_25_CYC;
			RATE_50: period_of = PERIOD_50_CYC;
			default: period_of = PERIOD_75_CYC;
		endcase
	endfunction

	assign rate = ctrl1_reg[C1_RATE_LSB +: 3];
	assign wr_cfg = reg_wr_i && reg_addr_i == ADDR_INT_CFG;
	assign wr_c1 = reg_wr_i && reg_addr_i == ADDR_CONTROL_ONE;
	assign wr_c2 = reg_wr_i && reg_addr_i == ADDR_CONTROL_TWO;
	assign rd_src = reg_rd_i && reg_addr_i == ADDR_INT_SOURCE;
	assign rd_top = reg_rd_i && reg_addr_i == ADDR_OUT_TOP;
	assign take = sample_valid_i && busy_reg;
	// codes 110 and 111 never tick, and unlike off they also refuse one-shot
	assign tick = rate != RATE_OFF && rate <= RATE_75 && cnt_reg >= period_of(rate) - 1;
	assign os_start = ctrl2_reg[C2_ONE_SHOT] && !busy_reg && rate == RATE_OFF;

	// filter only in continuous mode
	assign filt_on = ctrl1_reg[C1_FILT_EN] && rate != RATE_OFF;
	always_comb begin
		filt_step = $signed(sample_press_i) - $signed(filt_reg);
		if (ctrl1_reg[C1_FILT_CFG]) begin
			filt_step = filt_step >>> FILT_SHIFT_NARROWER;
		end else begin
			filt_step = filt_step >>> FILT_SHIFT_NARROW;
		end
		meas = filt_on ? $signed(filt_reg) + filt_step : $signed(sample_press_i);
		// a fresh capture compares against itself
		ref_use = (int_cfg_reg[IC_AZ_EN] || int_cfg_reg[IC_HOLD_EN]) ? meas : $signed(ref_reg);
		if (az_act_reg || int_cfg_reg[IC_AZ_EN]) begin
			out_val = meas - ref_use;
		end else if (hold_act_reg || int_cfg_reg[IC_HOLD_EN]) begin
			out_val = meas - $signed({{8{ofs_reg[15]}}, ofs_reg});
		end else begin
			out_val = meas;
		end
		if (az_act_reg || hold_act_reg || int_cfg_reg[IC_AZ_EN] || int_cfg_reg[IC_HOLD_EN]) begin
			comp = meas - ref_use;
		end else begin
			comp = meas;
		end
		comp_w = {{2{comp[23]}}, comp};
		thr_w = $signed({2'b00, thr_reg, 8'h00});
		hit_high = int_cfg_reg[IC_HIGH_EN] && comp_w > thr_w;
		hit_low = int_cfg_reg[IC_LOW_EN] && comp_w < -thr_w;
	end

	// interrupt configuration; reset bits are write-one pulses and read zero
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			int_cfg_reg <= INT_CFG_RST;
		end else if (wr_cfg) begin
			int_cfg_reg <= reg_wdata_i & ~8'h50;
		end else if (take) begin
			int_cfg_reg[IC_AZ_EN] <= 1'b0;
			int_cfg_reg[IC_HOLD_EN] <= 1'b0;
		end
	end

	// relative modes; a reset written with an enable wins
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			az_act_reg <= 1'b0;
			hold_act_reg <= 1'b0;
		end else begin
			if (wr_cfg && reg_wdata_i[IC_AZ_RST]) begin
				az_act_reg <= 1'b0;
			end else if (take && int_cfg_reg[IC_AZ_EN]) begin
				az_act_reg <= 1'b1;
			end
			if (wr_cfg && reg_wdata_i[IC_HOLD_RST]) begin
				hold_act_reg <= 1'b0;
			end else if (take && int_cfg_reg[IC_HOLD_EN]) begin
				hold_act_reg <= 1'b1;
			end
		end
	end

	// threshold, offset and reference bytes
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			thr_reg <= {THR_RST, THR_RST};
			ofs_reg <= 16'h0000;
			ref_reg <= 24'h000000;
		end else begin
			if (reg_wr_i && reg_addr_i == ADDR_THR_LOW) begin
				thr_reg[7:0] <= reg_wdata_i;
			end
			if (reg_wr_i && reg_addr_i == ADDR_THR_HIGH) begin
				thr_reg[15:8] <= reg_wdata_i;
			end
			if (reg_wr_i && reg_addr_i == ADDR_OFS_L) begin
				ofs_reg[7:0] <= reg_wdata_i;
			end
			if (reg_wr_i && reg_addr_i == ADDR_OFS_H) begin
				ofs_reg[15:8] <= reg_wdata_i;
			end
			if (wr_cfg && reg_wdata_i[IC_AZ_RST]) begin
				ref_reg <= 24'h000000;
			end else if (take && (int_cfg_reg[IC_AZ_EN] || int_cfg_reg[IC_HOLD_EN])) begin
				ref_reg <= meas;
			end else if (reg_wr_i && reg_addr_i == ADDR_REF_XL) begin
				ref_reg[7:0] <= reg_wdata_i;
			end else if (reg_wr_i && reg_addr_i == ADDR_REF_L) begin
				ref_reg[15:8] <= reg_wdata_i;
			end else if (reg_wr_i && reg_addr_i == ADDR_REF_H) begin
				ref_reg[23:16] <= reg_wdata_i;
			end
		end
	end

	// control registers; the top bit of control one is kept zero
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			ctrl1_reg <= CONTROL_ONE_RST;
			ctrl2_reg <= CONTROL_TWO_RST;
			wire_three_o <= 1'b0;
		end else begin
			if (wr_c1) begin
				ctrl1_reg <= {1'b0, reg_wdata_i[6:0]};
				wire_three_o <= reg_wdata_i[C1_WIRE];
			end
			if (wr_c2) begin
				ctrl2_reg[7:1] <= reg_wdata_i[7:1];
				ctrl2_reg[C2_ONE_SHOT] <= reg_wdata_i[C2_ONE_SHOT] && rate == RATE_OFF;
			end else if (take && rate == RATE_OFF) begin
				ctrl2_reg[C2_ONE_SHOT] <= 1'b0;
			end
		end
	end

	// rate divider and acquisition request
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			cnt_reg <= 32'h00000000;
			acquire_o <= 1'b0;
			busy_reg <= 1'b0;
		end else begin
			if (rate == RATE_OFF || tick || wr_c1) begin
				cnt_reg <= 32'h00000000;
			end else begin
				cnt_reg <= cnt_reg + 32'h00000001;
			end
			acquire_o <= tick || os_start;
			if (tick || os_start) begin
				busy_reg <= 1'b1;
			end else if (sample_valid_i) begin
				busy_reg <= 1'b0;
			end
		end
	end

	// output data, filter state and frozen flag; one-shot samples update them in power-down too
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			out_reg <= 24'h000000;
			filt_reg <= 24'h000000;
			frozen_reg <= 1'b0;
			avail_reg <= 1'b0;
		end else begin
			if (take) begin
				filt_reg <= meas;
			end
			if (take && !frozen_reg) begin
				out_reg <= out_val;
			end
			if (take && ctrl1_reg[C1_BLOCK]) begin
				frozen_reg <= 1'b1;
			end else if (rd_top || !ctrl1_reg[C1_BLOCK]) begin
				frozen_reg <= 1'b0;
			end
			if (take) begin
				avail_reg <= 1'b1;
			end else if (rd_top) begin
				avail_reg <= 1'b0;
			end
		end
	end

	// interrupt source; with latching a read clears, new hits win
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			src_reg <= 3'h0;
			press_high_o <= 1'b0;
			press_low_o <= 1'b0;
		end else begin
			if (take && int_cfg_reg[IC_THR_EN]) begin
				if (int_cfg_reg[IC_LATCH]) begin
					src_reg[SRC_HIGH] <= (src_reg[SRC_HIGH] && !rd_src) || hit_high;
					src_reg[SRC_LOW] <= (src_reg[SRC_LOW] && !rd_src) || hit_low;
					src_reg[SRC_ACTIVE] <= (src_reg[SRC_ACTIVE] && !rd_src) || hit_high || hit_low;
				end else begin
					src_reg <= {hit_high || hit_low, hit_low, hit_high};
				end
			end else if (!int_cfg_reg[IC_THR_EN]) begin
				src_reg <= 3'h0;
			end else if (rd_src && int_cfg_reg[IC_LATCH]) begin
				src_reg <= 3'h0;
			end
			press_high_o <= src_reg[SRC_HIGH];
			press_low_o <= src_reg[SRC_LOW];
		end
	end

	// register read port; unmapped addresses read zero
	always_ff @(posedge sys_clk_i) begin
		if (rst_i) begin
			reg_rdata_o <= 8'h00;
		end else if (reg_rd_i) begin
			unique case (reg_addr_i)
				ADDR_INT_CFG: reg_rdata_o <= int_cfg_reg;
				ADDR_THR_LOW: reg_rdata_o <= thr_reg[7:0];
				ADDR_THR_HIGH: reg_rdata_o <= thr_reg[15:8];
				ADDR_IDENTITY: reg_rdata_o <= ID_CODE;
				ADDR_CONTROL_ONE: reg_rdata_o <= ctrl1_reg;
				ADDR_CONTROL_TWO: reg_rdata_o <= ctrl2_reg;
				ADDR_REF_XL: reg_rdata_o <= ref_reg[7:0];
				ADDR_REF_L: reg_rdata_o <= ref_reg[15:8];
				ADDR_REF_H: reg_rdata_o <= ref_reg[23:16];
				ADDR_OFS_L: reg_rdata_o <= ofs_reg[7:0];
				ADDR_OFS_H: reg_rdata_o <= ofs_reg[15:8];
				ADDR_INT_SOURCE: reg_rdata_o <= {5'h00, src_reg};
				ADDR_STATUS: reg_rdata_o <= {7'h00, avail_reg};
				ADDR_OUT_XL: reg_rdata_o <= out_reg[7:0];
				ADDR_OUT_L: reg_rdata_o <= out_reg[15:8];
				ADDR_OUT_TOP: reg_rdata_o <= out_reg[23:16];
				default: reg_rdata_o <= 8'h00;
			endcase
		end
	end

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (rst_i);

	a_oneshot_refused: assert property (wr_c2 && reg_wdata_i[C2_ONE_SHOT] && rate != RATE_OFF |=> !ctrl2_reg[C2_ONE_SHOT])
		else $error("one-shot accepted outside power-down");
	a_oneshot_acquire: assert property (ctrl2_reg[C2_ONE_SHOT] && !busy_reg && rate == RATE_OFF |=> acquire_o && busy_reg)
		else $error("one-shot did not start acquisition");
	a_pdown_no_tick: assert property (rate == RATE_OFF && !ctrl2_reg[C2_ONE_SHOT] |=> !acquire_o)
		else $error("acquisition in power-down");
	a_az_selfclear: assert property (take && int_cfg_reg[IC_AZ_EN] && !wr_cfg |=> !int_cfg_reg[IC_AZ_EN] && az_act_reg)
		else $error("auto-zero enable did not self-clear");
	a_az_reset: assert property (wr_cfg && reg_wdata_i[IC_AZ_RST] |=> ref_reg == 24'h000000 && !az_act_reg)
		else $error("auto-zero reset incomplete");
	a_hold_selfclear: assert property (take && int_cfg_reg[IC_HOLD_EN] && !wr_cfg |=> !int_cfg_reg[IC_HOLD_EN] && hold_act_reg)
		else $error("reference-hold enable did not self-clear");
	a_hold_reset: assert property (wr_cfg && reg_wdata_i[IC_HOLD_RST] |=> !hold_act_reg)
		else $error("reference-hold reset ignored");
	a_bdu_freeze: assert property (frozen_reg && ctrl1_reg[C1_BLOCK] && !rd_top |=> $stable(out_reg))
		else $error("output changed while frozen");
	a_latch_hold: assert property (int_cfg_reg[IC_LATCH] && int_cfg_reg[IC_THR_EN] && src_reg[SRC_HIGH] && !rd_src && !wr_cfg |=> src_reg[SRC_HIGH])
		else $error("latched high event lost");
	a_high_pin: assert property (take && int_cfg_reg[IC_THR_EN] && hit_high |=> ##1 press_high_o)
		else $error("high event not on pin");
	a_identity_read: assert property (reg_rd_i && reg_addr_i == ADDR_IDENTITY |=> reg_rdata_o == ID_CODE)
		else $error("identity read wrong");

	c_oneshot: cover property (os_start ##[1:50] take);
	c_high_latched: cover property (take && hit_high && int_cfg_reg[IC_LATCH]);
	c_autozero: cover property (take && int_cfg_reg[IC_AZ_EN]);
	c_frozen_read: cover property (frozen_reg && rd_top);
endmodule

`default_nettype wire

// [pkg/ptr_pkg.sv]
// constants for the pressure threshold and rate control block
package ptr_pkg;
	localparam int unsigned CLK_HZ = 25_000_000;
	localparam int unsigned CLK_PERIOD_NS = 40;
	localparam int unsigned RATE_1_HZ = 1;
	localparam int unsigned RATE_10_HZ = 10;
	localparam int unsigned RATE_25_HZ = 25;
	localparam int unsigned RATE_50_HZ = 50;
	localparam int unsigned RATE_75_HZ = 75;
	localparam logic [6:0] ADDR_INT_CFG = 7'h0b;
	localparam logic [6:0] ADDR_THR_LOW = 7'h0c;
	localparam logic [6:0] ADDR_THR_HIGH = 7'h0d;
	localparam logic [6:0] ADDR_IDENTITY = 7'h0f;
	localparam logic [6:0] ADDR_CONTROL_ONE = 7'h10;
	localparam logic [6:0] ADDR_CONTROL_TWO = 7'h11;
	localparam logic [6:0] ADDR_REF_XL = 7'h15;
	localparam logic [6:0] ADDR_REF_L = 7'h16;
	localparam logic [6:0] ADDR_REF_H = 7'h17;
	localparam logic [6:0] ADDR_OFS_L = 7'h18;
	localparam logic [6:0] ADDR_OFS_H = 7'h19;
	localparam logic [6:0] ADDR_INT_SOURCE = 7'h25;
	localparam logic [6:0] ADDR_STATUS = 7'h27;
	localparam logic [6:0] ADDR_OUT_XL = 7'h28;
	localparam logic [6:0] ADDR_OUT_L = 7'h29;
	localparam logic [6:0] ADDR_OUT_TOP = 7'h2a;
	// interrupt configuration bit positions
	localparam int unsigned IC_HOLD_EN = 7;
	localparam int unsigned IC_HOLD_RST = 6;
	localparam int unsigned IC_AZ_EN = 5;
	localparam int unsigned IC_AZ_RST = 4;
	localparam int unsigned IC_THR_EN = 3;
	localparam int unsigned IC_LATCH = 2;
	localparam int unsigned IC_LOW_EN = 1;
	localparam int unsigned IC_HIGH_EN = 0;
	// control one and control two fields
	localparam int unsigned C1_RATE_LSB = 4;
	localparam int unsigned C1_FILT_EN = 3;
	localparam int unsigned C1_FILT_CFG = 2;
	localparam int unsigned C1_BLOCK = 1;
	localparam int unsigned C1_WIRE = 0;
	localparam int unsigned C2_ONE_SHOT = 0;
	// interrupt source and status bits
	localparam int unsigned SRC_HIGH = 0;
	localparam int unsigned SRC_LOW = 1;
	localparam int unsigned SRC_ACTIVE = 2;
	localparam int unsigned STAT_PRESS_AVAIL = 0;
	localparam logic [7:0] INT_CFG_RST = 8'h00;
	localparam logic [7:0] THR_RST = 8'h00;
	localparam logic [7:0] CONTROL_ONE_RST = 8'h00;
	localparam logic [7:0] CONTROL_TWO_RST = 8'h10;
	localparam logic [2:0] RATE_OFF = 3'h0;
	localparam logic [2:0] RATE_1 = 3'h1;
	localparam logic [2:0] RATE_10 = 3'h2;
	localparam logic [2:0] RATE_25 = 3'h3;
	localparam logic [2:0] RATE_50 = 3'h4;
	localparam logic [2:0] RATE_75 = 3'h5;
	// filter shifts: bandwidth roughly rate/9 and rate/20
	localparam int unsigned FILT_SHIFT_NARROW = 2;
	localparam int unsigned FILT_SHIFT_NARROWER = 3;
	// threshold counts to pressure counts (1/16 hPa versus 1/4096 hPa)
	localparam int unsigned THR_SHIFT = 8;
endpackage

// [dv/ptr_host.sv]
// host model that reaches the registers one byte at a time
`timescale 1ns/10ps
`default_nettype none
module ptr_host
	import ptr_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic [7:0] rdata_i,
	output logic wr_o,
	output logic rd_o,
	output logic [6:0] addr_o,
	output logic [7:0] wdata_o
);
	initial begin
		wr_o = 1'b0;
		rd_o = 1'b0;
		addr_o = 7'h00;
		wdata_o = 8'h00;
	end
	// strobes move on the falling edge only
	task automatic wr(input logic [6:0] a, input logic [7:0] d);
		@(negedge sys_clk_i);
		addr_o = a;
		wdata_o = d;
		wr_o = 1'b1;
		@(negedge sys_clk_i);
		wr_o = 1'b0;
		wdata_o = ~d;
	endtask
	task automatic rd(input logic [6:0] a, output logic [7:0] d);
		@(negedge sys_clk_i);
		addr_o = a;
		rd_o = 1'b1;
		@(negedge sys_clk_i);
		rd_o = 1'b0;
		d = rdata_i;
	endtask
	// top byte last, else a frozen set is released early
	task automatic rd_out(output logic [23:0] p);
		rd(ADDR_OUT_XL, p[7:0]);
		rd(ADDR_OUT_L, p[15:8]);
		rd(ADDR_OUT_TOP, p[23:16]);
	endtask
endmodule
`default_nettype wire

// [dv/ptr_core_tb.sv]
// self-checking bench for the threshold and rate block
`timescale 1ns/10ps
`default_nettype none
module ptr_core_tb;
	import ptr_pkg::*;
	localparam logic [7:0] ID = 8'h3c; // arbitrary value
	localparam int PER [1:5] = '{20, 10, 8, 6, 4};
	localparam logic [23:0] TV [7] = '{24'h011000, 24'h011001, 24'h000000, 24'hfef000,
		24'hfeefff, 24'h011001, 24'h000000};
	logic sys_clk_i, rst_i, sample_valid_i, reg_wr_i, reg_rd_i;
	logic acquire_o, wire_three_o, press_high_o, press_low_o;
	logic [23:0] sample_press_i, s1, v, fx;
	logic [6:0] reg_addr_i;
	logic [7:0] reg_wdata_i, reg_rdata_o, b;
	logic [15:0] lf;
	logic [1:0] e;
	int n_mismatch, cmp_count, n;
	ptr_core #(.ID_CODE(ID), .PERIOD_1_CYC(20), .PERIOD_10_CYC(10), .PERIOD_25_CYC(8),
		.PERIOD_50_CYC(6), .PERIOD_75_CYC(4)) u_ptr_core (.sys_clk_i(sys_clk_i), .rst_i(rst_i),
		.reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
		.sample_valid_i(sample_valid_i), .sample_press_i(sample_press_i), .reg_rdata_o(reg_rdata_o),
		.acquire_o(acquire_o), .wire_three_o(wire_three_o), .press_high_o(press_high_o),
		.press_low_o(press_low_o));
	ptr_host u_ptr_host (.sys_clk_i(sys_clk_i), .rdata_i(reg_rdata_o), .wr_o(reg_wr_i),
		.rd_o(reg_rd_i), .addr_o(reg_addr_i), .wdata_o(reg_wdata_i));
	initial begin
		sys_clk_i = 1'b0;
		forever #20 sys_clk_i = ~sys_clk_i;
	end
	function automatic logic [15:0] lfsr(input logic [15:0] x);
		return {x[14:0], x[15] ^ x[13] ^ x[12] ^ x[10]};
	endfunction
	// {low, high} of a difference against the threshold, strict on both sides
	function automatic logic [1:0] hits(input logic [23:0] d, input logic [15:0] t);
		int s;
		int m;
		s = $signed(d);
		m = int'(t) <<< 8;
		return {s < -m, s > m};
	endfunction
	// first-order step toward the new sample, arithmetic shift of the difference
	function automatic logic [23:0] filt_exp(input logic [23:0] f, input logic [23:0] p, input int sh);
		logic signed [23:0] d;
		d = $signed(p - f);
		return f + 24'(d >>> sh);
	endfunction
	task automatic chk(input logic [23:0] g, input logic [23:0] x);
		cmp_count++;
		if (g !== x) begin
			n_mismatch++;
			$display("[ERR] t=%0t got=%h exp=%h", $time, g, x);
		end
	endtask
	task automatic rdc(input logic [6:0] a, input logic [7:0] x);
		u_ptr_host.rd(a, b);
		chk({16'h0, b}, {16'h0, x});
	endtask
	task automatic out_chk(input logic [23:0] x);
		u_ptr_host.rd_out(v);
		chk(v, x);
	endtask
	task automatic pins(input logic [1:0] x);
		chk({22'h0, press_low_o, press_high_o}, {22'h0, x});
	endtask
	task automatic rnd(output logic [23:0] r);
		lf = lfsr(lf);
		r[23:16] = lf[15:8];
		lf = lfsr(lf);
		r[15:0] = lf;
	endtask
	task automatic wait_acq();
		n = 0;
		while (acquire_o !== 1'b1 && n < 40) begin
			@(negedge sys_clk_i);
			n++;
		end
		chk({23'h0, acquire_o}, 24'h1);
	endtask
	task automatic shot(input logic [23:0] p);
		u_ptr_host.wr(ADDR_CONTROL_TWO, 8'h01);
		feed(p);
	endtask
	// one sample pulse once the next acquisition request shows
	task automatic feed(input logic [23:0] p);
		wait_acq();
		sample_press_i = p;
		sample_valid_i = 1'b1;
		@(negedge sys_clk_i);
		sample_valid_i = 1'b0;
		sample_press_i = ~p;
		repeat (3) @(negedge sys_clk_i);
	endtask
	task automatic t_end(input string s);
		$display("done: %s", s);
	endtask
	task automatic close_out();
		$display("compares=%0d mismatches=%0d", cmp_count, n_mismatch);
		if (n_mismatch == 0 && cmp_count > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	initial begin
		#(CLK_PERIOD_NS * 20000);
		n_mismatch++;
		close_out();
	end
	initial begin
		n_mismatch = 0;
		cmp_count = 0;
		lf = 16'ha0ef;
		rst_i = 1'b1;
		sample_valid_i = 1'b0;
		sample_press_i = 24'h0;
		repeat (8) @(posedge sys_clk_i);
		@(negedge sys_clk_i);
		rst_i = 1'b0;
		rdc(ADDR_INT_CFG, 8'h00);
		rdc(ADDR_THR_LOW, 8'h00);
		rdc(ADDR_CONTROL_ONE, 8'h00);
		u_ptr_host.wr(ADDR_IDENTITY, 8'h00);
		rdc(ADDR_IDENTITY, ID);
		rdc(7'h0e, 8'h00);
		for (int i = 1; i >= 0; i--) begin
			u_ptr_host.wr(ADDR_CONTROL_ONE, 8'(i));
			rdc(ADDR_CONTROL_ONE, 8'(i));
			chk({23'h0, wire_three_o}, 24'(i));
		end
		t_end("reset, identity, wire mode");
		// each rate: gap between starts, then drain with the same value
		for (int k = 1; k <= 5; k++) begin
			u_ptr_host.wr(ADDR_CONTROL_ONE, 8'(k << 4));
			wait_acq();
			rnd(s1);
			sample_press_i = s1;
			sample_valid_i = 1'b1;
			n = 0;
			do begin
				@(negedge sys_clk_i);
				sample_valid_i = 1'b0;
				n++;
			end while (acquire_o !== 1'b1 && n < 40);
			chk(24'(n), 24'(PER[k]));
			out_chk(s1);
			if (k == 1) begin
				u_ptr_host.wr(ADDR_CONTROL_TWO, 8'h01);
				rdc(ADDR_CONTROL_TWO, 8'h00);
			end
			u_ptr_host.wr(ADDR_CONTROL_ONE, 8'h00);
			sample_valid_i = 1'b1;
			@(negedge sys_clk_i);
			sample_valid_i = 1'b0;
		end
		n = 0;
		repeat (30) begin
			@(negedge sys_clk_i);
			if (acquire_o === 1'b1) begin
				n++;
			end
		end
		chk(24'(n), 24'h0);
		out_chk(s1);
		t_end("rates and power-down");
		u_ptr_host.wr(ADDR_THR_LOW, 8'h10);
		u_ptr_host.wr(ADDR_THR_HIGH, 8'h01);
		rdc(ADDR_THR_HIGH, 8'h01);
		u_ptr_host.wr(ADDR_INT_CFG, 8'h0b);
		e = 2'b00;
		for (int i = 0; i < 7; i++) begin
			if (i == 5) begin
				u_ptr_host.wr(ADDR_INT_CFG, 8'h0f);
			end
			e = (i >= 5 ? e : 2'b00) | hits(TV[i], 16'h0110);
			shot(TV[i]);
			pins(e);
		end
		rdc(ADDR_INT_SOURCE, 8'h07);
		repeat (2) @(negedge sys_clk_i);
		pins(2'b00);
		t_end("threshold and latch");
		rnd(s1);
		u_ptr_host.wr(ADDR_INT_CFG, 8'h2b);
		shot(s1);
		rdc(ADDR_STATUS, 8'h01);
		out_chk(24'h0);
		rdc(ADDR_STATUS, 8'h00);
		rdc(ADDR_INT_CFG, 8'h0b);
		rdc(ADDR_REF_H, s1[23:16]);
		shot(s1 + 24'h011001);
		pins(2'b01);
		out_chk(24'h011001);
		u_ptr_host.wr(ADDR_INT_CFG, 8'h1b);
		rdc(ADDR_REF_XL, 8'h00);
		rdc(ADDR_REF_H, 8'h00);
		shot(s1);
		out_chk(s1);
		t_end("auto-zero");
		// negative offset, so sign extension shows
		u_ptr_host.wr(ADDR_OFS_L, 8'h34);
		u_ptr_host.wr(ADDR_OFS_H, 8'h92);
		rnd(s1);
		u_ptr_host.wr(ADDR_INT_CFG, 8'h8b);
		shot(s1);
		out_chk(s1 - 24'hff9234);
		rdc(ADDR_INT_CFG, 8'h0b);
		rdc(ADDR_REF_L, s1[15:8]);
		shot(s1 - 24'h011001);
		pins(2'b10);
		out_chk(s1 - 24'h011001 - 24'hff9234);
		u_ptr_host.wr(ADDR_INT_CFG, 8'h4b);
		shot(s1);
		out_chk(s1);
		t_end("reference hold");
		u_ptr_host.wr(ADDR_CONTROL_ONE, 8'h02);
		shot(24'h123456);
		shot(24'h654321);
		out_chk(24'h123456);
		shot(24'h0abcde);
		out_chk(24'h0abcde);
		t_end("block update");
		// filter state is the last taken value, so the first filtered step is known
		fx = 24'h0abcde;
		for (int c = 0; c < 2; c++) begin
			u_ptr_host.wr(ADDR_CONTROL_ONE, 8'h18 | 8'(c << 2));
			rnd(s1);
			feed(s1);
			fx = filt_exp(fx, s1, c == 1 ? FILT_SHIFT_NARROWER : FILT_SHIFT_NARROW);
			out_chk(fx);
		end
		t_end("low-pass filter");
		close_out();
	end
endmodule
`default_nettype wire
